// [dfwp_assertions.sv]
/*
 Concurrent checks of the word profile block.
 Assumes binding into dfwp_top on core_clk.
*/
`timescale 1ns/1ps
module dfwp_chk
	import dfwp_pkg::*;
(
	// Clock, reset and bus
	input wire logic        core_clk,
	input wire logic        reset_n,
	input wire logic [4:0]  avs_address,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable,
	input wire logic        avs_waitrequest,
	// Drive side
	input wire logic        din_stop,
	input dfwp_cmd_t        cmd,
	input wire logic        trip_reset_pulse,
	input wire logic        allow_freeze_stop
);
	logic        cw_take;
	logic [15:0] cw_r;
	assign cw_take = avs_write && !avs_waitrequest && avs_address == 5'h00
		&& avs_byteenable[1:0] == 2'h3;
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			cw_r <= 16'h0000;
		end else if (cw_take) begin
			cw_r <= avs_writedata[15:0];
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	chk_stop_bits: assert property (
		cw_take && avs_writedata[10] |-> ##2 cmd.dc_brake == !cw_r[2]
		&& cmd.coast == !cw_r[3] && cmd.quick_stop == !cw_r[4]
		&& cmd.ramp_stop == !cw_r[6]) else $error("stop bits wrong");
	chk_hold_jog: assert property (
		cw_take && avs_writedata[10] |-> ##2 cmd.freeze == !cw_r[5]
		&& cmd.jog == cw_r[8] && cmd.ramp2 == cw_r[9])
		else $error("hold jog ramp wrong");
	chk_preset_pick: assert property (
		cw_take && avs_writedata[10] |-> ##2 cmd.preset == cw_r[1:0])
		else $error("preset index wrong");
	chk_invalid_word: assert property (
		cw_take && !avs_writedata[10] |=> $stable(cmd) [*2])
		else $error("invalid word acted on");
	chk_pulse_single: assert property (
		trip_reset_pulse |=> !trip_reset_pulse)
		else $error("reset pulse too long");
	chk_pulse_cause: assert property (
		trip_reset_pulse |-> ##[0:1] cmd.trip_reset)
		else $error("reset pulse without bit");
	chk_freeze_cmd: assert property (
		cmd.coast || cmd.dc_brake |-> allow_freeze_stop)
		else $error("freeze stop not allowed");
	chk_freeze_din: assert property (
		din_stop [*3] |-> allow_freeze_stop)
		else $error("input stop not allowed");
endmodule
bind dfwp_top dfwp_chk chk_u (.core_clk, .reset_n, .avs_address,
	.avs_write, .avs_writedata, .avs_byteenable, .avs_waitrequest,
	.din_stop, .cmd, .trip_reset_pulse, .allow_freeze_stop);

// [dfwp_defines.svh]
/*
 Bit positions of the command word and constants of the words and registers.
 Assumes inclusion by the top module only; the package does not include it.
*/
`ifndef DFWP_DEFINES_SVH
`define DFWP_DEFINES_SVH
`define DFWP_CW_PRESET_LO   0
`define DFWP_CW_PRESET_HI   1
`define DFWP_CW_RAMP        2
`define DFWP_CW_NO_COAST    3
`define DFWP_CW_NO_QSTOP    4
`define DFWP_CW_USE_RAMP    5
`define DFWP_CW_START       6
`define DFWP_CW_RESET       7
`define DFWP_CW_JOG         8
`define DFWP_CW_RAMP2       9
`define DFWP_CW_VALID       10
`define DFWP_CW_RELAY1      11
`define DFWP_CW_RELAY2      12
`define DFWP_CW_SETUP_LO    13
`define DFWP_CW_SETUP_HI    14
`define DFWP_CW_REVERSE     15
`define DFWP_FULL_SCALE     16'h4000
`define DFWP_WORD_RESET     16'h0000
`define DFWP_REG_COMMAND    4'h0
`define DFWP_REG_SPEED_REF  4'h4
`define DFWP_REG_STATE      4'h8
`define DFWP_REG_ACTUAL     4'hC
`define DFWP_REG_CONFIG     5'h10
`define DFWP_REG_DRIVE      5'h14
`define DFWP_REG_CONFIG_RST 32'h0000_0000
`define DFWP_UNMAPPED_RDATA 32'h0000_0000
`define DFWP_REV_DIGITAL    2'h0
`define DFWP_REV_SERIAL     2'h1
`define DFWP_REV_OR         2'h2
`define DFWP_REV_AND        2'h3
`endif

// [dfwp_master_model.sv]
/*
 Behavioural fieldbus master posting words over Avalon-MM.
 Assumes the bench calls its task between rising edges.
*/
`timescale 1ns/1ps
module dfwp_master_model (
	// Answer
	input  wire logic        core_clk,
	input  wire logic        avs_waitrequest,
	input  wire logic [31:0] avs_readdata,
	// Request
	output logic      [4:0]  avs_address,
	output logic             avs_read,
	output logic             avs_write,
	output logic      [31:0] avs_writedata,
	output logic      [3:0]  avs_byteenable
);
	initial begin
		avs_address = 5'h1F;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'hFFFF_FFFF;
		avs_byteenable = 4'h0;
	end
	task automatic access(input logic [4:0] a, input logic w,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge core_clk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		avs_byteenable <= 4'h3;
		do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		avs_address <= ~a;
		avs_writedata <= ~d;
	endtask
endmodule

// [dfwp_pkg.sv]
/*
 Types for the fieldbus word profile block.
 Assumes the defines header is in the include path.
*/
package dfwp_pkg;
	typedef struct packed {
		logic        dc_brake;
		logic        coast;
		logic        quick_stop;
		logic        freeze;
		logic        ramp_stop;
		logic        trip_reset;
		logic        jog;
		logic        ramp2;
		logic        relay1;
		logic        relay2;
		logic [1:0]  setup;
		logic [1:0]  preset;
		logic        reverse;
	} dfwp_cmd_t;
	typedef struct packed {
		logic        ctrl_ready;
		logic        drive_ready;
		logic        enabled;
		logic        trip;
		logic        error;
		logic        trip_lock;
		logic        warning;
		logic        at_ref;
		logic        bus_ctrl;
		logic        in_limit;
		logic        running;
		logic        auto_stop;
		logic        volt_bad;
		logic        torque_bad;
		logic        timer_bad;
	} dfwp_drive_t;
	typedef enum logic [1:0] {
		DFWP_IDLE,
		DFWP_ANSWER
	} dfwp_bus_state_t;
endpackage

// [dfwp_top.sv]
/*
 Command word decoder and state report word encoder of a drive.
 Assumes an Avalon-MM master on core_clk and drive status inputs
 from asynchronous logic, which are synchronised here.
*/
// The placing of the registers and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps
`include "dfwp_defines.svh"
module dfwp_top
	import dfwp_pkg::*;
(
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        reset_n,
	// Avalon-MM slave
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// Drive status, asynchronous
	input  wire logic [14:0] drive_status,
	input  wire logic        link_ok,
	input  wire logic        local_stop,
	input  wire logic        local_ref,
	input  wire logic        din_stop,
	input  wire logic        din_reverse,
	input  wire logic [15:0] actual_output_value,
	// Decoded commands
	output dfwp_cmd_t        cmd,
	output logic             trip_reset_pulse,
	output logic      [15:0] speed_reference,
	output logic             allow_freeze_stop
);
	logic [15:0]     command_word_r;
	logic [15:0]     speed_ref_r;
	logic [31:0]     config_r;
	logic [15:0]     state_report_word_r;
	logic [15:0]     actual_r;
	logic            reset_bit_d_r;
	dfwp_cmd_t       cmd_r;
	dfwp_bus_state_t bus_state_r;
	logic [19:0]     sync1_r;
	logic [19:0]     sync2_r;
	logic [15:0]     act1_r;
	logic [15:0]     act2_r;
	logic [31:0]     rdata_nxt;
	logic            wr_go;
	logic            rd_go;
	logic            relay1_en;
	logic            relay2_en;
	logic            multi_setup;
	logic [1:0]      rev_src;
	logic [15:0]     cw;
	dfwp_drive_t     ds;
	logic            s_link;
	logic            s_lstop;
	logic            s_lref;
	logic            s_dstop;
	logic            s_drev;
	logic            bus_rev;

	// Status synchroniser
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			sync1_r <= 20'h00000;
			sync2_r <= 20'h00000;
			act1_r <= `DFWP_WORD_RESET;
			act2_r <= `DFWP_WORD_RESET;
		end else begin
			sync1_r <= {drive_status, link_ok, local_stop, local_ref,
				din_stop, din_reverse};
			sync2_r <= sync1_r;
			act1_r <= actual_output_value;
			act2_r <= act1_r;
		end
	end

	assign ds = dfwp_drive_t'(sync2_r[19:5]);
	assign s_link = sync2_r[4];
	assign s_lstop = sync2_r[3];
	assign s_lref = sync2_r[2];
	assign s_dstop = sync2_r[1];
	assign s_drev = sync2_r[0];

	// Configuration fields
	assign relay1_en = config_r[0];
	assign relay2_en = config_r[1];
	assign multi_setup = config_r[2];
	assign rev_src = config_r[5:4];

	// Bus handshake, one wait cycle
	assign wr_go = avs_write && (bus_state_r == DFWP_ANSWER);
	assign rd_go = avs_read && (bus_state_r == DFWP_ANSWER);
	assign avs_waitrequest = (avs_read || avs_write) &&
		(bus_state_r != DFWP_ANSWER);

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			bus_state_r <= DFWP_IDLE;
		end else begin
			case (bus_state_r)
				DFWP_IDLE: begin
					if (avs_read || avs_write) begin
						bus_state_r <= DFWP_ANSWER;
					end
				end
				default: begin
					bus_state_r <= DFWP_IDLE;
				end
			endcase
		end
	end

	// Register writes
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			command_word_r <= `DFWP_WORD_RESET;
			speed_ref_r <= `DFWP_WORD_RESET;
			config_r <= `DFWP_REG_CONFIG_RST;
		end else if (wr_go) begin
			if (avs_address == `DFWP_REG_COMMAND) begin
				if (avs_byteenable[0]) begin
					command_word_r[7:0] <= avs_writedata[7:0];
				end
				if (avs_byteenable[1]) begin
					command_word_r[15:8] <= avs_writedata[15:8];
				end
			end else if (avs_address == `DFWP_REG_SPEED_REF) begin
				if (avs_byteenable[0]) begin
					speed_ref_r[7:0] <= avs_writedata[7:0];
				end
				if (avs_byteenable[1]) begin
					speed_ref_r[15:8] <= avs_writedata[15:8];
				end
			end else if (avs_address == `DFWP_REG_CONFIG) begin
				if (avs_byteenable[0]) begin
					config_r[7:0] <= avs_writedata[7:0];
				end
			end
		end
	end

	assign cw = command_word_r;
	assign bus_rev = cw[`DFWP_CW_REVERSE];

	// Command decode
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			cmd_r <= '0;
			reset_bit_d_r <= 1'b0;
			trip_reset_pulse <= 1'b0;
		end else begin
			trip_reset_pulse <= 1'b0;
			if (cw[`DFWP_CW_VALID]) begin
				cmd_r.preset <= cw[`DFWP_CW_PRESET_HI:`DFWP_CW_PRESET_LO];
				cmd_r.dc_brake <= !cw[`DFWP_CW_RAMP];
				cmd_r.coast <= !cw[`DFWP_CW_NO_COAST];
				cmd_r.quick_stop <= !cw[`DFWP_CW_NO_QSTOP];
				cmd_r.freeze <= !cw[`DFWP_CW_USE_RAMP];
				cmd_r.ramp_stop <= !cw[`DFWP_CW_START];
				cmd_r.jog <= cw[`DFWP_CW_JOG];
				cmd_r.ramp2 <= cw[`DFWP_CW_RAMP2];
				cmd_r.relay1 <= cw[`DFWP_CW_RELAY1] && relay1_en;
				cmd_r.relay2 <= cw[`DFWP_CW_RELAY2] && relay2_en;
				if (multi_setup) begin
					cmd_r.setup <= cw[`DFWP_CW_SETUP_HI:`DFWP_CW_SETUP_LO];
				end
				if (rev_src == `DFWP_REV_SERIAL) begin
					cmd_r.reverse <= bus_rev;
				end else if (rev_src == `DFWP_REV_OR) begin
					cmd_r.reverse <= bus_rev || s_drev;
				end else if (rev_src == `DFWP_REV_AND) begin
					cmd_r.reverse <= bus_rev && s_drev;
				end else begin
					cmd_r.reverse <= s_drev;
				end
				reset_bit_d_r <= cw[`DFWP_CW_RESET];
				trip_reset_pulse <= cw[`DFWP_CW_RESET] && !reset_bit_d_r;
				cmd_r.trip_reset <= cw[`DFWP_CW_RESET];
			end
		end
	end

	assign cmd = cmd_r;
	assign allow_freeze_stop = cmd_r.coast || cmd_r.dc_brake || s_dstop;

	assign speed_reference = speed_ref_r;

	// State report encode
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_report_word_r <= `DFWP_WORD_RESET;
			actual_r <= `DFWP_WORD_RESET;
		end else begin
			actual_r <= act2_r;
			if (!s_link) begin
				state_report_word_r <= `DFWP_WORD_RESET;
			end else begin
				state_report_word_r[0] <= ds.ctrl_ready;
				state_report_word_r[1] <= ds.drive_ready;
				state_report_word_r[2] <= ds.enabled;
				state_report_word_r[3] <= ds.trip;
				state_report_word_r[4] <= ds.error;
				state_report_word_r[5] <= 1'b0;
				state_report_word_r[6] <= ds.trip_lock;
				state_report_word_r[7] <= ds.warning;
				state_report_word_r[8] <= ds.at_ref;
				state_report_word_r[9] <= ds.bus_ctrl && !s_lstop && !s_lref;
				state_report_word_r[10] <= ds.in_limit;
				state_report_word_r[11] <= ds.running;
				state_report_word_r[12] <= ds.auto_stop;
				state_report_word_r[15] <= ds.timer_bad;
				state_report_word_r[13] <= ds.volt_bad;
				state_report_word_r[14] <= ds.torque_bad;
			end
		end
	end

	// Read mux
	always_comb begin
		rdata_nxt = `DFWP_UNMAPPED_RDATA;
		if (avs_address == `DFWP_REG_COMMAND) begin
			rdata_nxt = {16'h0000, command_word_r};
		end else if (avs_address == `DFWP_REG_SPEED_REF) begin
			rdata_nxt = {16'h0000, speed_ref_r};
		end else if (avs_address == `DFWP_REG_STATE) begin
			rdata_nxt = {16'h0000, state_report_word_r};
		end else if (avs_address == `DFWP_REG_ACTUAL) begin
			rdata_nxt = {16'h0000, actual_r};
		end else if (avs_address == `DFWP_REG_CONFIG) begin
			rdata_nxt = {24'h000000, config_r[7:0]};
		end else if (avs_address == `DFWP_REG_DRIVE) begin
			rdata_nxt = {16'h0000, 1'b0, cmd_r};
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			avs_readdata <= `DFWP_UNMAPPED_RDATA;
		end else if (avs_read && bus_state_r == DFWP_IDLE) begin
			avs_readdata <= rdata_nxt;
		end
	end
endmodule

// [testbench.sv]
/*
 Self-checking bench of the word profile block.
 Assumes the master model and the bound checker.
*/
`timescale 1ns/1ps
module testbench;
	import dfwp_pkg::*;
	logic        core_clk, reset_n, avs_read, avs_write, avs_waitrequest;
	logic [4:0]  avs_address;
	logic [3:0]  avs_byteenable;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic [14:0] drive_status;
	logic        link_ok, local_stop, local_ref, din_stop, din_reverse;
	logic [15:0] actual_output_value, speed_reference;
	dfwp_cmd_t   cmd;
	logic        trip_reset_pulse, allow_freeze_stop;
	int          fail_count, total_checks, pulses;
	dfwp_top dut_u (.core_clk, .reset_n, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
		.avs_waitrequest, .drive_status, .link_ok, .local_stop,
		.local_ref, .din_stop, .din_reverse, .actual_output_value,
		.cmd, .trip_reset_pulse, .speed_reference, .allow_freeze_stop);
	dfwp_master_model m_u (.core_clk, .avs_waitrequest, .avs_readdata,
		.avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable);
	always #20 core_clk = ~core_clk;
	always @(posedge core_clk) if (trip_reset_pulse === 1'b1) pulses++;
	task automatic check(input string n, input logic [31:0] e, s);
		total_checks++;
		if (s !== e) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		m_u.access(a, 1'b1, d, q);
	endtask
	task automatic rd(input logic [4:0] a);
		m_u.access(a, 1'b0, 32'h0, q);
	endtask
	function automatic dfwp_cmd_t exp_cmd(input logic [15:0] w,
		input logic [5:0] c, input logic [1:0] s);
		return '{!w[2], !w[3], !w[4], !w[5], !w[6], w[7], w[8], w[9],
			w[11] & c[0], w[12] & c[1], c[2] ? w[14:13] : s, w[1:0],
			w[15] & (c[5:4] == 2'h1 || c[5:4] == 2'h2)};
	endfunction
	task automatic t_reset;
		check("cmd", 32'h0, {17'h0, cmd});
		rd(5'h10);
		check("config", 32'h0, q);
		wr(5'h18, 32'hFFFF_FFFF);
		rd(5'h18);
		check("unmapped", 32'h0, q);
		$display("test reset done");
	endtask
	task automatic t_decode;
		logic [15:0] tab [4];
		logic [5:0]  c;
		dfwp_cmd_t   e;
		tab = '{16'hFFFF, 16'h8C03, 16'hA5F6, 16'hDE09};
		e = '0;
		for (int i = 0; i < 4; i++) begin
			c = {i[1:0], 1'b0, i[0] ? 3'h7 : 3'h2};
			wr(5'h10, {26'h0, c});
			wr(5'h00, {16'h0, tab[i]});
			e = exp_cmd(tab[i], c, e.setup);
			repeat (2) @(negedge core_clk);
			check("cmd", {17'h0, e}, {17'h0, cmd});
		end
		wr(5'h00, 32'h0000_03FF);
		repeat (2) @(negedge core_clk);
		check("held cmd", {17'h0, e}, {17'h0, cmd});
		@(posedge core_clk);
		din_reverse <= 1'b1;
		wr(5'h10, 32'h0000_0030);
		wr(5'h00, 32'h0000_8400);
		repeat (2) @(negedge core_clk);
		check("reverse and", 32'h1, {31'h0, cmd.reverse});
		@(posedge core_clk);
		din_reverse <= 1'b0;
		$display("test decode done");
	endtask
	task automatic t_edge;
		pulses = 0;
		wr(5'h00, 32'h0480);
		wr(5'h00, 32'h0480);
		wr(5'h00, 32'h0400);
		wr(5'h00, 32'h0480);
		repeat (3) @(negedge core_clk);
		check("pulses", 32'h2, pulses);
		$display("test reset edge done");
	endtask
	task automatic t_status;
		int          pos [15];
		logic [15:0] e [4];
		pos = '{0, 1, 2, 3, 4, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15};
		e = '{16'hFFDF, 16'hFDDF, 16'hFDDF, 16'h0000};
		wr(5'h00, 32'h0000_040C);
		repeat (2) @(negedge core_clk);
		check("no freeze stop", 32'h0, {31'h0, allow_freeze_stop});
		@(posedge core_clk);
		for (int j = 0; j < 19; j++) begin
			drive_status <= (j < 15) ? 15'h4000 >> j : 15'h7FFF;
			local_stop <= (j == 16);
			local_ref <= (j == 17);
			link_ok <= (j != 18);
			din_stop <= (j == 18);
			repeat (4) @(posedge core_clk);
			rd(5'h08);
			if (j < 15) begin
				check("state", 32'h1 << pos[j], {16'h0, q[15:0]});
			end else begin
				check("state", {16'h0, e[j - 15]}, {16'h0, q[15:0]});
			end
		end
		check("freeze stop", 32'h1, {31'h0, allow_freeze_stop});
		din_stop <= 1'b0;
		link_ok <= 1'b1;
		$display("test state word done");
	endtask
	task automatic t_speed;
		logic [15:0] v [2];
		v = '{16'h4000, 16'hC000};
		for (int i = 0; i < 2; i++) begin
			actual_output_value <= v[i];
			wr(5'h04, {16'h0, v[i]});
			wr(5'h0C, 32'h1234);
			rd(5'h04);
			check("speed", {16'h0, v[i]}, {16'h0, speed_reference});
			check("speed rd", {16'h0, v[i]}, {16'h0, q[15:0]});
			rd(5'h0C);
			check("actual", {16'h0, v[i]}, {16'h0, q[15:0]});
		end
		$display("test scaling done");
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		{core_clk, reset_n, local_stop, local_ref, din_stop} = 5'h00;
		din_reverse = 1'b0;
		{drive_status, actual_output_value} = 31'h0;
		link_ok = 1'b1;
		{fail_count, total_checks, pulses} = '0;
		repeat (6) @(posedge core_clk);
		reset_n <= 1'b1;
		t_reset;
		t_decode;
		t_edge;
		t_status;
		t_speed;
		summarize;
	end
	initial begin
		#400000;
		fail_count++;
		summarize;
	end
endmodule
